//--- include/kphm_pkg.sv
package kphm_pkg;

	// ==========================================================
	// Host I/O addresses
	localparam int          HOST_ADDR_W    = 10;
	localparam logic [9:0]  HOST_KBD_DATA  = 10'h060;
	localparam logic [9:0]  HOST_KBD_CMD   = 10'h064;
	localparam logic [9:0]  HOST_PM_DATA   = 10'h062;
	localparam logic [9:0]  HOST_PM_CMD    = 10'h066;
	localparam int          HOST_A2_BIT    = 2;

	// ==========================================================
	// Firmware register indexes
	localparam int          FW_IDX_W       = 4;
	localparam logic [3:0]  IDX_INTF_CTRL  = 4'h0;
	localparam logic [3:0]  IDX_IRQ_CTRL   = 4'h1;
	localparam logic [3:0]  IDX_KBD_STAT   = 4'h2;
	localparam logic [3:0]  IDX_KBD_OUT    = 4'h3;
	localparam logic [3:0]  IDX_MOUSE_OUT  = 4'h4;
	localparam logic [3:0]  IDX_KBD_IN     = 4'h5;
	localparam logic [3:0]  IDX_PM_STAT    = 4'h6;
	localparam logic [3:0]  IDX_PM_OUT     = 4'h7;
	localparam logic [3:0]  IDX_PM_IN      = 4'h8;

	// ==========================================================
	// Reset values and field masks
	localparam logic [7:0]  IRQ_CTRL_RST   = 8'h07;
	localparam logic [7:0]  INTF_CTRL_RST  = 8'h00;
	localparam logic [7:0]  STATUS_RST     = 8'h00;
	localparam logic [7:0]  INTF_CTRL_MASK = 8'h7F;
	localparam logic [7:0]  STATUS_FW_MASK = 8'hF4;

	// ==========================================================
	// Host interrupt lines and pulse forms
	localparam int          IRQ_LINES      = 3;
	localparam int          LINE_KBD       = 0;
	localparam int          LINE_MOUSE     = 1;
	localparam int          LINE_PM        = 2;
	localparam int          PULSE_CNT_W    = 5;
	localparam logic [2:0]  FORM_LEVEL     = 3'h0;
	localparam logic [2:0]  FORM_PULSE_MAX = 3'h5;

	// ==========================================================
	// Register layouts
	typedef struct packed {
		logic [3:0] flags;
		logic       a2;
		logic       f0;
		logic       in_buffer_full;
		logic       out_buffer_full;
	} kphm_status_t;

	typedef struct packed {
		logic       push_pull;
		logic       invert;
		logic [2:0] form;
		logic [2:0] direct;
	} kphm_irqc_t;

	typedef struct packed {
		logic       reserved;
		logic       pm_full_core_en;
		logic       pm_empty_core_en;
		logic       pm_host_en;
		logic       kbd_full_core_en;
		logic       kbd_empty_core_en;
		logic       mouse_host_en;
		logic       kbd_host_en;
	} kphm_ctrl_t;

endpackage : kphm_pkg

//--- rtl/kphm_mailbox.sv
`timescale 1ns/1ps
// Behaviour
// - Interrupt control resets to 07h
// - Direct bits drive lines; reads return pins
// - Mode field: level or 1..16 cycle pulses
// - Level mode: idle low, high while full
// - Pulse mode: idle high, low pulse on write
// - Invert bit inverts hardware-generated lines only
// - Bit 7 selects push-pull, else open drain
// - Keyboard status resets zero, host reads 64h
// - Output full: fw write sets, 60h read clears
// - Input full: host write sets, fw read clears
// - Keyboard status bit 3 captures A2
// - Flag bits writable by firmware, host-readable
// - Mouse out write loads, flags, raises IRQ12
// - Keyboard out writes clear empty core interrupt
// - Keyboard in read returns byte, clears full
// - Power status resets zero, host reads 66h
// - Power full flags set and clear correctly
// - Power status bit 3 captures A2
// - Power out write loads, flags, raises IRQ11
// - Power in read returns byte, clears full
// - Host enable hands line to hardware
module kphm_mailbox
	import kphm_pkg::*;
(
	input  wire logic                   MCLK,
	input  wire logic                   RESETN,
	input  wire logic [HOST_ADDR_W-1:0] HOST_ADDR,
	input  wire logic                   HOST_IOR_N,
	input  wire logic                   HOST_IOW_N,
	input  wire logic [7:0]             HOST_DATA_IN,
	output logic      [7:0]             HOST_DATA_OUT,
	output logic                        HOST_DATA_OE,
	input  wire logic [IRQ_LINES-1:0]   IRQ_PIN_IN,
	output logic      [IRQ_LINES-1:0]   IRQ_PIN_OUT,
	output logic      [IRQ_LINES-1:0]   IRQ_PIN_OE,
	input  wire logic [FW_IDX_W-1:0]    FW_INDEX,
	input  wire logic                   FW_WR,
	input  wire logic                   FW_RD,
	input  wire logic [7:0]             FW_WDATA,
	output logic      [7:0]             FW_RDATA,
	output logic                        KBD_EMPTY_CORE_IRQ,
	output logic                        KBD_FULL_CORE_IRQ,
	output logic                        PM_EMPTY_CORE_IRQ,
	output logic                        PM_FULL_CORE_IRQ
);

	// ==========================================================
	// Host pin synchronisers
	logic [HOST_ADDR_W-1:0] addr_s1_q;
	logic [HOST_ADDR_W-1:0] addr_s2_q;
	logic [7:0]             data_s1_q;
	logic [7:0]             data_s2_q;
	logic                   ior_s1_q;
	logic                   ior_s2_q;
	logic                   ior_s3_q;
	logic                   iow_s1_q;
	logic                   iow_s2_q;
	logic                   iow_s3_q;
	logic [IRQ_LINES-1:0]   pin_s1_q;
	logic [IRQ_LINES-1:0]   pin_s2_q;

	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			addr_s1_q <= '0;
			addr_s2_q <= '0;
			data_s1_q <= 8'h00;
			data_s2_q <= 8'h00;
			ior_s1_q  <= 1'b1;
			ior_s2_q  <= 1'b1;
			ior_s3_q  <= 1'b1;
			iow_s1_q  <= 1'b1;
			iow_s2_q  <= 1'b1;
			iow_s3_q  <= 1'b1;
			pin_s1_q  <= '1;
			pin_s2_q  <= '1;
		end
		else
		begin
			addr_s1_q <= HOST_ADDR;
			addr_s2_q <= addr_s1_q;
			data_s1_q <= HOST_DATA_IN;
			data_s2_q <= data_s1_q;
			ior_s1_q  <= HOST_IOR_N;
			ior_s2_q  <= ior_s1_q;
			ior_s3_q  <= ior_s2_q;
			iow_s1_q  <= HOST_IOW_N;
			iow_s2_q  <= iow_s1_q;
			iow_s3_q  <= iow_s2_q;
			pin_s1_q  <= IRQ_PIN_IN;
			pin_s2_q  <= pin_s1_q;
		end
	end

	// ==========================================================
	// Host strobe decode
	logic rd_start;
	logic rd_end;
	logic wr_end;
	logic hit_kd;
	logic hit_kc;
	logic hit_pd;
	logic hit_pc;
	logic host_a2;

	assign rd_start = ior_s3_q & ~ior_s2_q;
	assign rd_end   = ~ior_s3_q & ior_s2_q;
	assign wr_end   = ~iow_s3_q & iow_s2_q;
	assign hit_kd   = (addr_s2_q == HOST_KBD_DATA);
	assign hit_kc   = (addr_s2_q == HOST_KBD_CMD);
	assign hit_pd   = (addr_s2_q == HOST_PM_DATA);
	assign hit_pc   = (addr_s2_q == HOST_PM_CMD);
	assign host_a2  = addr_s2_q[HOST_A2_BIT];

	// ==========================================================
	// Firmware access decode
	logic fw_wr_kout;
	logic fw_wr_mout;
	logic fw_wr_pout;
	logic fw_rd_kin;
	logic fw_rd_pin;

	assign fw_wr_kout = FW_WR & (FW_INDEX == IDX_KBD_OUT);
	assign fw_wr_mout = FW_WR & (FW_INDEX == IDX_MOUSE_OUT);
	assign fw_wr_pout = FW_WR & (FW_INDEX == IDX_PM_OUT);
	assign fw_rd_kin  = FW_RD & (FW_INDEX == IDX_KBD_IN);
	assign fw_rd_pin  = FW_RD & (FW_INDEX == IDX_PM_IN);

	// ==========================================================
	// Control registers
	kphm_ctrl_t ctrl_q;
	kphm_irqc_t irqc_q;

	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			ctrl_q <= kphm_ctrl_t'(INTF_CTRL_RST);
		else if (FW_WR && FW_INDEX == IDX_INTF_CTRL)
			ctrl_q <= kphm_ctrl_t'(FW_WDATA & INTF_CTRL_MASK);
	end

	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			irqc_q <= kphm_irqc_t'(IRQ_CTRL_RST);
		else if (FW_WR && FW_INDEX == IDX_IRQ_CTRL)
			irqc_q <= kphm_irqc_t'(FW_WDATA);
	end

	// ==========================================================
	// Keyboard channel
	kphm_status_t kst_q;
	logic [7:0]   kin_q;
	logic [7:0]   kout_q;
	logic         kout_mouse_q;

	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			kst_q <= kphm_status_t'(STATUS_RST);
		else
		begin
			if (FW_WR && FW_INDEX == IDX_KBD_STAT)
			begin
				kst_q.flags <= FW_WDATA[7:4];
				kst_q.f0    <= FW_WDATA[2];
			end
			if (fw_wr_kout || fw_wr_mout)
				kst_q.out_buffer_full <= 1'b1;
			else if (rd_end && hit_kd)
				kst_q.out_buffer_full <= 1'b0;
			if (wr_end && (hit_kd || hit_kc))
			begin
				kst_q.in_buffer_full <= 1'b1;
				kst_q.a2  <= host_a2;
			end
			else if (fw_rd_kin)
				kst_q.in_buffer_full <= 1'b0;
		end
	end

	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			kin_q <= 8'h00;
		else if (wr_end && (hit_kd || hit_kc))
			kin_q <= data_s2_q;
	end

	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			kout_q       <= 8'h00;
			kout_mouse_q <= 1'b0;
		end
		else if (fw_wr_kout || fw_wr_mout)
		begin
			kout_q       <= FW_WDATA;
			kout_mouse_q <= fw_wr_mout;
		end
	end

	// ==========================================================
	// Power management channel
	kphm_status_t pst_q;
	logic [7:0]   pin_q;
	logic [7:0]   pout_q;

	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			pst_q <= kphm_status_t'(STATUS_RST);
		else
		begin
			if (FW_WR && FW_INDEX == IDX_PM_STAT)
			begin
				pst_q.flags <= FW_WDATA[7:4];
				pst_q.f0    <= FW_WDATA[2];
			end
			if (fw_wr_pout)
				pst_q.out_buffer_full <= 1'b1;
			else if (rd_end && hit_pd)
				pst_q.out_buffer_full <= 1'b0;
			if (wr_end && (hit_pd || hit_pc))
			begin
				pst_q.in_buffer_full <= 1'b1;
				pst_q.a2  <= host_a2;
			end
			else if (fw_rd_pin)
				pst_q.in_buffer_full <= 1'b0;
		end
	end

	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			pin_q <= 8'h00;
		else if (wr_end && (hit_pd || hit_pc))
			pin_q <= data_s2_q;
	end

	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			pout_q <= 8'h00;
		else if (fw_wr_pout)
			pout_q <= FW_WDATA;
	end

	// ==========================================================
	// Host read data
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			HOST_DATA_OUT <= 8'h00;
			HOST_DATA_OE  <= 1'b0;
		end
		else if (rd_start && (hit_kd || hit_kc || hit_pd || hit_pc))
		begin
			HOST_DATA_OE <= 1'b1;
			if (hit_kd)
				HOST_DATA_OUT <= kout_q;
			else if (hit_kc)
				HOST_DATA_OUT <= kst_q;
			else if (hit_pd)
				HOST_DATA_OUT <= pout_q;
			else
				HOST_DATA_OUT <= pst_q;
		end
		else if (ior_s2_q)
			HOST_DATA_OE <= 1'b0;
	end

	// ==========================================================
	// Firmware read data
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			FW_RDATA <= 8'h00;
		else if (FW_RD)
		begin
			unique case (FW_INDEX)
				IDX_INTF_CTRL: FW_RDATA <= ctrl_q;
				IDX_IRQ_CTRL:  FW_RDATA <= {irqc_q[7:3], pin_s2_q};
				IDX_KBD_STAT:  FW_RDATA <= kst_q;
				IDX_KBD_IN:    FW_RDATA <= kin_q;
				IDX_PM_STAT:   FW_RDATA <= pst_q;
				IDX_PM_IN:     FW_RDATA <= pin_q;
				default:       FW_RDATA <= 8'h00;
			endcase
		end
	end

	// ==========================================================
	// Core interrupts
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			KBD_EMPTY_CORE_IRQ <= 1'b0;
			KBD_FULL_CORE_IRQ  <= 1'b0;
			PM_EMPTY_CORE_IRQ  <= 1'b0;
			PM_FULL_CORE_IRQ   <= 1'b0;
		end
		else
		begin
			KBD_EMPTY_CORE_IRQ <= ctrl_q.kbd_empty_core_en & ~kst_q.out_buffer_full;
			KBD_FULL_CORE_IRQ  <= ctrl_q.kbd_full_core_en & kst_q.in_buffer_full;
			PM_EMPTY_CORE_IRQ  <= ctrl_q.pm_empty_core_en & ~pst_q.out_buffer_full;
			PM_FULL_CORE_IRQ   <= ctrl_q.pm_full_core_en & pst_q.in_buffer_full;
		end
	end

	// ==========================================================
	// Host interrupt lines
	logic [IRQ_LINES-1:0]   hw_en;
	logic [IRQ_LINES-1:0]   trig;
	logic [IRQ_LINES-1:0]   owned;
	logic [PULSE_CNT_W-1:0] width;
	logic                   pulse_mode;

	assign hw_en = {ctrl_q.pm_host_en, ctrl_q.mouse_host_en, ctrl_q.kbd_host_en};
	assign trig  = {fw_wr_pout, fw_wr_mout, fw_wr_kout};
	assign owned = {pst_q.out_buffer_full, kst_q.out_buffer_full & kout_mouse_q, kst_q.out_buffer_full & ~kout_mouse_q};

	always_comb
	begin
		pulse_mode = 1'b0;
		width      = '0;
		if (irqc_q.form != FORM_LEVEL && irqc_q.form <= FORM_PULSE_MAX)
		begin
			pulse_mode = 1'b1;
			width      = PULSE_CNT_W'(1) << (irqc_q.form - 3'h1);
		end
	end

	generate
		for (genvar i = 0; i < IRQ_LINES; i++)
		begin : g_line
			logic [PULSE_CNT_W-1:0] cnt_q;
			logic                   lvl;

			always_ff @(posedge MCLK or negedge RESETN)
			begin
				if (!RESETN)
					cnt_q <= '0;
				else if (trig[i] && hw_en[i] && pulse_mode)
					cnt_q <= width;
				else if (cnt_q != '0)
					cnt_q <= cnt_q - PULSE_CNT_W'(1);
			end

			always_comb
			begin
				if (!hw_en[i])
					lvl = irqc_q.direct[i];
				else if (pulse_mode)
					lvl = (cnt_q == '0) ^ irqc_q.invert;
				else if (irqc_q.form == FORM_LEVEL)
					lvl = owned[i] ^ irqc_q.invert;
				else
					lvl = irqc_q.invert;
			end

			always_ff @(posedge MCLK or negedge RESETN)
			begin
				if (!RESETN)
				begin
					IRQ_PIN_OUT[i] <= 1'b0;
					IRQ_PIN_OE[i]  <= 1'b0;
				end
				else
				begin
					IRQ_PIN_OUT[i] <= lvl & irqc_q.push_pull;
					IRQ_PIN_OE[i]  <= irqc_q.push_pull | ~lvl;
				end
			end
		end
	endgenerate

endmodule : kphm_mailbox

//--- test/kphm_host_model.sv
`timescale 1ns/1ps
module kphm_host_model
	import kphm_pkg::*;
(
	input  wire logic                   mclk,
	output logic      [HOST_ADDR_W-1:0] host_addr,
	output logic                        ior_n,
	output logic                        iow_n,
	output logic      [7:0]             data_in,
	input  wire logic [7:0]             data_out,
	input  wire logic                   data_oe
);
	initial
	begin
		host_addr = 10'h000;
		ior_n = 1'b1;
		iow_n = 1'b1;
		data_in = 8'h00;
	end

	// ==========================================================
	// Host write: caller only writes while input full is clear
	task automatic host_wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge mclk);
		host_addr <= a;
		data_in <= d;
		iow_n <= 1'b0;
		repeat (4) @(posedge mclk);
		iow_n <= 1'b1;
		repeat (4) @(posedge mclk);
		data_in <= ~d;
		host_addr <= ~a;
	endtask : host_wr

	// ==========================================================
	// Host read: data is taken once data_oe is seen, waiting up to 10 clocks
	task automatic host_rd(input logic [9:0] a, output logic [7:0] d, output logic ok);
		int i;
		@(posedge mclk);
		host_addr <= a;
		ior_n <= 1'b0;
		ok = 1'b0;
		for (i = 0; i < 10 && !ok; i++)
		begin
			@(negedge mclk);
			ok = (data_oe === 1'b1);
		end
		d = data_out;
		@(posedge mclk);
		ior_n <= 1'b1;
		repeat (6) @(posedge mclk);
		host_addr <= ~a;
	endtask : host_rd
endmodule : kphm_host_model

//--- test/kphm_mailbox_chk.sv
`timescale 1ns/1ps
module kphm_mailbox_chk
	import kphm_pkg::*;
(
	input wire logic                   MCLK,
	input wire logic                   RESETN,
	input wire logic [HOST_ADDR_W-1:0] HOST_ADDR,
	input wire logic                   HOST_IOR_N,
	input wire logic                   HOST_DATA_OE,
	input wire logic [IRQ_LINES-1:0]   IRQ_PIN_OUT,
	input wire logic [IRQ_LINES-1:0]   IRQ_PIN_OE,
	input wire logic [FW_IDX_W-1:0]    FW_INDEX,
	input wire logic                   FW_WR,
	input wire logic                   FW_RD,
	input wire logic [7:0]             FW_WDATA,
	input wire logic [7:0]             FW_RDATA,
	input wire logic                   KBD_EMPTY_CORE_IRQ,
	input wire logic                   KBD_FULL_CORE_IRQ,
	input wire logic                   PM_EMPTY_CORE_IRQ,
	input wire logic                   PM_FULL_CORE_IRQ
);
	logic pp_q;
	logic host_hit;

	// ==========================================================
	// Helper state
	assign host_hit = (HOST_ADDR == HOST_KBD_DATA) || (HOST_ADDR == HOST_KBD_CMD)
		|| (HOST_ADDR == HOST_PM_DATA) || (HOST_ADDR == HOST_PM_CMD);

	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			pp_q <= 1'b0;
		else if (FW_WR && FW_INDEX == IDX_IRQ_CTRL)
			pp_q <= FW_WDATA[7];
	end

	default clocking dc @(posedge MCLK);
	endclocking
	default disable iff (!RESETN);

	// ==========================================================
	// Assertions
	kbd_empty_clr_a: assert property ((FW_WR && (FW_INDEX == IDX_KBD_OUT
		|| FW_INDEX == IDX_MOUSE_OUT)) |-> ##2 !KBD_EMPTY_CORE_IRQ)
		else $error("kbd empty core irq still high after out write");
	pm_empty_clr_a: assert property (FW_WR && FW_INDEX == IDX_PM_OUT |-> ##2 !PM_EMPTY_CORE_IRQ)
		else $error("pm empty core irq still high after out write");
	kbd_full_clr_a: assert property (FW_RD && FW_INDEX == IDX_KBD_IN |-> ##2 !KBD_FULL_CORE_IRQ)
		else $error("kbd full core irq still high after in read");
	pm_full_clr_a: assert property (FW_RD && FW_INDEX == IDX_PM_IN |-> ##2 !PM_FULL_CORE_IRQ)
		else $error("pm full core irq still high after in read");
	host_oe_rise_a: assert property ($fell(HOST_IOR_N) && host_hit |-> ##[2:5] HOST_DATA_OE)
		else $error("host read of mapped port not answered");
	host_oe_fall_a: assert property ($rose(HOST_IOR_N) |-> ##[1:5] !HOST_DATA_OE)
		else $error("host data still driven after read end");
	host_oe_void_a: assert property ((!HOST_IOR_N && !host_hit) [*6] |-> !HOST_DATA_OE)
		else $error("host data driven for unmapped address");
	fw_rd_void_a: assert property ((FW_RD && (FW_INDEX > IDX_PM_IN
		|| FW_INDEX == IDX_KBD_OUT)) |=> FW_RDATA == 8'h00)
		else $error("write-only or unmapped index read nonzero");
	od_out_low_a: assert property (!pp_q && !$past(pp_q) |-> IRQ_PIN_OUT == 3'h0)
		else $error("open drain irq drives high");
	pp_drive_a: assert property (pp_q && $past(pp_q) |-> IRQ_PIN_OE == 3'h7)
		else $error("push pull irq not driven");

	cov_kbd_wr: cover property (FW_WR && FW_INDEX == IDX_KBD_OUT);
	cov_host_rd: cover property ($rose(HOST_DATA_OE));
	cov_pm_irq: cover property (IRQ_PIN_OE[2] && IRQ_PIN_OUT[2]);
endmodule : kphm_mailbox_chk

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import kphm_pkg::*;
;
	logic                   MCLK;
	logic                   RESETN;
	logic [FW_IDX_W-1:0]    fw_index;
	logic                   fw_wr;
	logic                   fw_rd;
	logic [7:0]             fw_wdata;
	logic [7:0]             fw_rdata;
	logic [HOST_ADDR_W-1:0] host_addr;
	logic                   ior_n;
	logic                   iow_n;
	logic [7:0]             hdata_in;
	logic [7:0]             hdata_out;
	logic                   hdata_oe;
	logic [2:0]             irq_out;
	logic [2:0]             irq_oe;
	logic [2:0]             irq_wire;
	logic                   kbd_empty;
	logic                   kbd_full;
	logic                   pm_empty;
	logic                   pm_full;
	logic [7:0]             v;
	logic [7:0]             e;
	logic                   st;
	int                     cnt;
	int                     err_total = 0;
	int                     n_tests = 0;

	// ==========================================================
	// Design, host and pulled-up interrupt wires
	assign irq_wire = (irq_oe & irq_out) | ~irq_oe;

	kphm_mailbox dut_u (.MCLK(MCLK), .RESETN(RESETN), .HOST_ADDR(host_addr),
		.HOST_IOR_N(ior_n), .HOST_IOW_N(iow_n), .HOST_DATA_IN(hdata_in),
		.HOST_DATA_OUT(hdata_out), .HOST_DATA_OE(hdata_oe), .IRQ_PIN_IN(irq_wire),
		.IRQ_PIN_OUT(irq_out), .IRQ_PIN_OE(irq_oe), .FW_INDEX(fw_index), .FW_WR(fw_wr),
		.FW_RD(fw_rd), .FW_WDATA(fw_wdata), .FW_RDATA(fw_rdata),
		.KBD_EMPTY_CORE_IRQ(kbd_empty), .KBD_FULL_CORE_IRQ(kbd_full),
		.PM_EMPTY_CORE_IRQ(pm_empty), .PM_FULL_CORE_IRQ(pm_full));

	kphm_host_model host_u (.mclk(MCLK), .host_addr(host_addr), .ior_n(ior_n),
		.iow_n(iow_n), .data_in(hdata_in), .data_out(hdata_out), .data_oe(hdata_oe));

	always #25 MCLK = ~MCLK;

	// ==========================================================
	// Tasks
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic fw_write(input logic [3:0] idx, input logic [7:0] d);
		@(posedge MCLK);
		fw_index <= idx;
		fw_wdata <= d;
		fw_wr <= 1'b1;
		@(posedge MCLK);
		fw_wr <= 1'b0;
	endtask : fw_write

	task automatic fw_read(input logic [3:0] idx, output logic [7:0] d);
		@(posedge MCLK);
		fw_index <= idx;
		fw_rd <= 1'b1;
		@(posedge MCLK);
		fw_rd <= 1'b0;
		@(posedge MCLK);
		@(negedge MCLK);
		d = fw_rdata;
	endtask : fw_read

	task automatic hrd(input logic [9:0] a, input logic [7:0] x, input logic xok);
		logic [7:0] d;
		logic       ok;
		host_u.host_rd(a, d, ok);
		chk("host_oe", {7'h00, ok}, {7'h00, xok});
		if (xok)
			chk("host_data", d, x);
	endtask : hrd

	task automatic pins(input logic [2:0] x);
		repeat (3) @(negedge MCLK);
		chk("irq_pins", {5'h00, irq_wire}, {5'h00, x});
	endtask : pins

	task automatic end_sim;
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	// ==========================================================
	// Sequence
	initial
	begin
		MCLK = 1'b0;
		RESETN = 1'b0;
		fw_index = 4'h0;
		fw_wr = 1'b0;
		fw_rd = 1'b0;
		fw_wdata = 8'h00;
		repeat (20) @(posedge MCLK);
		RESETN <= 1'b1;
		fw_read(IDX_IRQ_CTRL, v); chk("irqc", v, 8'h07);
		fw_read(IDX_KBD_STAT, v); chk("kst", v, 8'h00);
		fw_read(IDX_PM_STAT, v); chk("pst", v, 8'h00);
		hrd(HOST_KBD_CMD, 8'h00, 1'b1);
		hrd(HOST_PM_CMD, 8'h00, 1'b1);
		hrd(10'h070, 8'h00, 1'b0);
		fw_read(4'h9, v);
		chk("void_idx", v, 8'h00);
		fw_read(IDX_KBD_OUT, v);
		chk("wo_idx", v, 8'h00);
		fw_write(IDX_IRQ_CTRL, 8'h85); pins(3'h5);
		fw_read(IDX_IRQ_CTRL, v); chk("irqc", v, 8'h85);
		fw_write(IDX_IRQ_CTRL, 8'h02); pins(3'h2);
		fw_write(IDX_INTF_CTRL, 8'h0F);
		host_u.host_wr(HOST_KBD_DATA, 8'hA5);
		fw_read(IDX_KBD_STAT, v); chk("kst", v, 8'h02);
		chk("kfull", {7'h00, kbd_full}, 8'h01);
		fw_read(IDX_KBD_IN, v); chk("kin", v, 8'hA5);
		host_u.host_wr(HOST_KBD_CMD, 8'hC3);
		fw_read(IDX_KBD_STAT, v); chk("kst", v, 8'h0A);
		fw_read(IDX_KBD_IN, v); chk("kin", v, 8'hC3);
		chk("kfull", {7'h00, kbd_full}, 8'h00);
		fw_write(IDX_KBD_STAT, 8'hF7);
		hrd(HOST_KBD_CMD, 8'hFC, 1'b1);
		fw_write(IDX_KBD_STAT, 8'h00);
		fw_write(IDX_IRQ_CTRL, 8'h80); pins(3'h0);
		chk("kempty", {7'h00, kbd_empty}, 8'h01);
		fw_write(IDX_KBD_OUT, 8'h5A); pins(3'h1);
		fw_read(IDX_KBD_STAT, v); chk("kst", v, 8'h09);
		chk("kempty", {7'h00, kbd_empty}, 8'h00);
		hrd(HOST_KBD_DATA, 8'h5A, 1'b1); pins(3'h0);
		fw_read(IDX_KBD_STAT, v); chk("kst", v, 8'h08);
		fw_write(IDX_MOUSE_OUT, 8'h3C); pins(3'h2);
		hrd(HOST_KBD_DATA, 8'h3C, 1'b1);
		fw_write(IDX_IRQ_CTRL, 8'hC0); pins(3'h3);
		for (int i = 1; i < 8; i++)
		begin
			fw_write(IDX_IRQ_CTRL, {2'b10, 3'(i), 3'h0});
			repeat (4) @(negedge MCLK);
			st = irq_wire[0];
			if (i < 6)
				chk("idle", {7'h00, st}, 8'h01);
			fw_write(IDX_KBD_OUT, 8'(i));
			cnt = 0;
			repeat (24) @(negedge MCLK) if (irq_wire[0] !== st) cnt++;
			e = (i < 6) ? (8'h01 << (i - 1)) : 8'h00;
			chk("pulse", cnt[7:0], e);
		end
		hrd(HOST_KBD_DATA, 8'h07, 1'b1);
		fw_write(IDX_INTF_CTRL, 8'h70);
		fw_write(IDX_IRQ_CTRL, 8'h80);
		host_u.host_wr(HOST_PM_CMD, 8'h9E);
		fw_read(IDX_PM_STAT, v); chk("pst", v, 8'h0A);
		chk("pfull", {7'h00, pm_full}, 8'h01);
		fw_read(IDX_PM_IN, v); chk("pin", v, 8'h9E);
		chk("pfull", {7'h00, pm_full}, 8'h00);
		fw_write(IDX_PM_OUT, 8'h77); pins(3'h4);
		chk("pempty", {7'h00, pm_empty}, 8'h00);
		hrd(HOST_PM_DATA, 8'h77, 1'b1);
		fw_read(IDX_PM_STAT, v); chk("pst", v, 8'h08);
		host_u.host_wr(HOST_PM_DATA, 8'h11);
		fw_read(IDX_PM_STAT, v); chk("pst", v, 8'h02);
		fw_write(IDX_PM_STAT, 8'hFF);
		hrd(HOST_PM_CMD, 8'hF6, 1'b1);
		end_sim();
	end
endmodule : tb_top

bind kphm_mailbox kphm_mailbox_chk chk_u (.MCLK(MCLK), .RESETN(RESETN),
	.HOST_ADDR(HOST_ADDR), .HOST_IOR_N(HOST_IOR_N), .HOST_DATA_OE(HOST_DATA_OE),
	.IRQ_PIN_OUT(IRQ_PIN_OUT), .IRQ_PIN_OE(IRQ_PIN_OE), .FW_INDEX(FW_INDEX),
	.FW_WR(FW_WR), .FW_RD(FW_RD), .FW_WDATA(FW_WDATA), .FW_RDATA(FW_RDATA),
	.KBD_EMPTY_CORE_IRQ(KBD_EMPTY_CORE_IRQ), .KBD_FULL_CORE_IRQ(KBD_FULL_CORE_IRQ),
	.PM_EMPTY_CORE_IRQ(PM_EMPTY_CORE_IRQ), .PM_FULL_CORE_IRQ(PM_FULL_CORE_IRQ));
